// [common/bwu_regs.svh]
`ifndef BWU_REGS_SVH
`define BWU_REGS_SVH
// register indices (word addresses are index * 4)
`define BWU_ADDR_W 6
`define BWU_PADDR_BASE 6'h00
`define BWU_PCTRL_BASE 6'h08
`define BWU_DADDR_BASE 6'h10
`define BWU_DVAL_BASE 6'h12
`define BWU_DCTRL_BASE 6'h14
`define BWU_TRIG_OFF 6'h16
`define BWU_STAT_OFF 6'h17
// field positions
`define BWU_EN_HI 31
`define BWU_EN_LO 30
`define BWU_RMASK_BIT 25
`define BWU_EVO_BIT 14
`define BWU_DIR_HI 29
`define BWU_DIR_LO 28
`define BWU_MASK_HI 23
`define BWU_MASK_LO 20
`define BWU_OPA_BIT 17
`define BWU_OPV_BIT 16
`define BWU_SIZE_HI 11
`define BWU_SIZE_LO 9
`define BWU_PBEG_HI 31
`define BWU_PBEG_LO 29
`define BWU_PSTP_HI 28
`define BWU_PSTP_LO 26
`define BWU_DBEG_HI 25
`define BWU_DBEG_LO 23
`define BWU_DSTP_HI 22
`define BWU_DSTP_LO 20
// writable bit masks
`define BWU_PCTRL_A_WMASK 32'hc200_4000
`define BWU_PCTRL_B_WMASK 32'hc000_4000
`define BWU_DCTRL_WMASK 32'hf0f3_4e00
`define BWU_TRIG_WMASK 32'hfff0_0000
`define BWU_RESET_VAL 32'h0000_0000
// message codes
`define BWU_TCODE_THIT 6'h38
`define BWU_TCODE_WH 6'h0f
`endif

// [common/bwu_pkg.sv]
package bwu_pkg;
    typedef enum logic [1:0] {BWU_EN_OFF, BWU_EN_BRK, BWU_EN_RSV,
        BWU_EN_WATCH} bwu_en_e;
    typedef enum logic [1:0] {BWU_SZ_BYTE, BWU_SZ_HALF, BWU_SZ_WORD,
        BWU_SZ_RSV} bwu_size_e;
    typedef logic [31:0] bwu_word_t;
endpackage

// [verilog/bwu_regmem.sv]
`timescale 1ns/1ns
`include "bwu_regs.svh"
// small register memory, registered read data
module bwu_regmem
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [2:0] waddr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [2:0] raddr_i,
    output logic [31:0] rdata_o,
    output logic [31:0] all_o [8]
);
    logic [31:0] mem_q [8];
    logic [31:0] mem_d [8];
    logic [31:0] rdata_d;

    always_comb
    begin
        mem_d = mem_q;
        if (we_i)
        begin
            mem_d[waddr_i] = wdata_i;
        end
        rdata_d = mem_q[raddr_i];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 8; i++)
            begin
                mem_q[i] <= `BWU_RESET_VAL;
            end
            rdata_o <= `BWU_RESET_VAL;
        end
        else
        begin
            mem_q <= mem_d;
            rdata_o <= rdata_d;
        end
    end

    assign all_o = mem_q;
endmodule // bwu_regmem

// [verilog/bwu_dmatch.sv]
`timescale 1ns/1ns
`include "bwu_regs.svh"
// combinational data compare for one data module
module bwu_dmatch
(
    input wire logic [31:0] ctrl_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] value_i,
    input wire logic [31:0] bus_addr_i,
    input wire logic [31:0] bus_data_i,
    input wire logic bus_write_i,
    input wire logic [1:0] bus_size_i,
    output logic hit_o
);
    import bwu_pkg::*;
    logic [31:0] lane_keep;
    logic dir_ok;
    logic size_ok;
    logic addr_ok;
    logic val_ok;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            lane_keep[i*8 +: 8] = {8{~ctrl_i[`BWU_MASK_LO + i]}};
        end
        case (ctrl_i[`BWU_DIR_HI:`BWU_DIR_LO])
            2'h0: dir_ok = ~bus_write_i;
            2'h1: dir_ok = bus_write_i;
            2'h2: dir_ok = 1'b1;
            default: dir_ok = 1'b0;
        endcase
        case (ctrl_i[`BWU_SIZE_HI:`BWU_SIZE_LO])
            3'h4: size_ok = bus_size_i == BWU_SZ_BYTE;
            3'h5: size_ok = bus_size_i == BWU_SZ_HALF;
            3'h6: size_ok = bus_size_i == BWU_SZ_WORD;
            3'h7: size_ok = 1'b0;
            default: size_ok = 1'b1;
        endcase
        addr_ok = ~ctrl_i[`BWU_OPA_BIT] | (bus_addr_i == addr_i);
        val_ok = ~ctrl_i[`BWU_OPV_BIT]
            | ((bus_data_i & lane_keep) == (value_i & lane_keep));
        hit_o = (ctrl_i[`BWU_OPA_BIT] | ctrl_i[`BWU_OPV_BIT])
            & addr_ok & val_ok & dir_ok & size_ok;
    end
endmodule // bwu_dmatch

// [verilog/bwu_top.sv]
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "bwu_regs.svh"
module bwu_top
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic debug_mode_i,
    input wire logic event_out_select_i,
    input wire logic pc_valid_i,
    input wire logic [31:0] pc_i,
    input wire logic dacc_valid_i,
    input wire logic [31:0] dacc_addr_i,
    input wire logic [31:0] dacc_data_i,
    input wire logic dacc_write_i,
    input wire logic [1:0] dacc_size_i,
    input wire logic dacc_done_i,
    input wire logic [1:0] trace_wp_i,
    output logic pc_break_o,
    output logic data_break_o,
    output logic [7:0] watch_hit_o,
    output logic watch_msg_o,
    output logic [5:0] watch_tcode_o,
    output logic [1:0] trace_hit_o,
    output logic trace_msg_o,
    output logic [5:0] trace_tcode_o,
    output logic event_out_pin_o,
    output logic prog_trace_en_o,
    output logic data_trace_en_o,
    output logic data_event_keep_o
);
    import bwu_pkg::*;

    logic [31:0] paddr [6];
    logic [31:0] pctrl [6];
    logic [31:0] daddr [2];
    logic [31:0] dval [2];
    logic [31:0] dctrl [2];
    logic [31:0] trig_q, trig_d;
    logic [31:0] memall [8];
    logic [31:0] mem_rdata;
    logic mem_we;
    logic [2:0] mem_waddr;
    logic [31:0] mem_wdata;
    logic rd_mem_q, rd_mem_d;
    logic [31:0] rd_reg_q, rd_reg_d;
    logic [31:0] rdata_d;
    logic [31:0] ctl_d [8];
    logic [31:0] ctl_q [8];
    logic [5:0] prog_raw, prog_hit;
    logic [1:0] data_raw;
    logic [1:0] data_pend_q, data_pend_d;
    logic [7:0] wp_ev;
    logic pc_break_d, data_break_d;
    logic [7:0] watch_hit_d;
    logic watch_msg_d, trace_msg_d;
    logic [1:0] trace_hit_d;
    logic evo_d;
    logic pt_q, pt_d, dt_q, dt_d, keep_d;
    logic [7:0] pctrl_evo;

    // 32-bit write to reserved bits is dropped by masking
    function automatic logic [31:0] wmask(input logic [5:0] idx);
        if (idx >= `BWU_PCTRL_BASE && idx < `BWU_PCTRL_BASE + 6'h6)
            wmask = idx[0] ? `BWU_PCTRL_B_WMASK : `BWU_PCTRL_A_WMASK;
        else if (idx >= `BWU_DCTRL_BASE && idx < `BWU_DCTRL_BASE + 6'h2)
            wmask = `BWU_DCTRL_WMASK;
        else if (idx == `BWU_TRIG_OFF)
            wmask = `BWU_TRIG_WMASK;
        else
            wmask = 32'hffff_ffff;
    endfunction

    // enable field decode
    function automatic logic en_is(input logic [31:0] c, input bwu_en_e e);
        en_is = bwu_en_e'(c[`BWU_EN_HI:`BWU_EN_LO]) == e;
    endfunction

    function automatic logic sel_hit(input logic [2:0] s,
        input logic [7:0] ev);
        sel_hit = (s != 3'h0) && ev[s];
    endfunction

    // program addresses kept in small memory
    bwu_regmem u_mem
    (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_i(reg_addr_i[2:0]),
        .rdata_o(mem_rdata),
        .all_o(memall)
    );

    always_comb
    begin
        mem_we = reg_wr_i && reg_addr_i < 6'h6;
        mem_waddr = reg_addr_i[2:0];
        mem_wdata = reg_wdata_i;
        for (int i = 0; i < 6; i++)
        begin
            paddr[i] = memall[i];
        end
    end

    // program control and trigger registers
    always_comb
    begin
        ctl_d = ctl_q;
        trig_d = trig_q;
        if (reg_wr_i && reg_addr_i >= `BWU_PCTRL_BASE
            && reg_addr_i < `BWU_PCTRL_BASE + 6'h6)
        begin
            ctl_d[reg_addr_i[2:0]] = reg_wdata_i & wmask(reg_addr_i);
        end
        if (reg_wr_i && reg_addr_i == `BWU_TRIG_OFF)
        begin
            trig_d = reg_wdata_i & `BWU_TRIG_WMASK;
        end
    end

    // separate banks: pctrl in ctl_q[0..5], data in dq
    logic [31:0] dq_q [6];
    logic [31:0] dq_d [6];
    always_comb
    begin
        dq_d = dq_q;
        if (reg_wr_i && reg_addr_i >= `BWU_DADDR_BASE
            && reg_addr_i < `BWU_DCTRL_BASE + 6'h2)
        begin
            dq_d[3'(reg_addr_i - `BWU_DADDR_BASE)] =
                reg_wdata_i & wmask(reg_addr_i);
        end
        for (int i = 0; i < 6; i++)
        begin
            pctrl[i] = ctl_q[i];
        end
        daddr[0] = dq_q[0];
        daddr[1] = dq_q[1];
        dval[0] = dq_q[2];
        dval[1] = dq_q[3];
        dctrl[0] = dq_q[4];
        dctrl[1] = dq_q[5];
    end

    // program compare
    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            if (pctrl[2*p][`BWU_RMASK_BIT])
            begin
                prog_raw[2*p] = (pc_i & paddr[2*p+1])
                    == (paddr[2*p] & paddr[2*p+1]);
                prog_raw[2*p+1] = 1'b0;
            end
            else
            begin
                prog_raw[2*p] = pc_i == paddr[2*p];
                prog_raw[2*p+1] = pc_i == paddr[2*p+1];
            end
        end
        prog_hit = prog_raw & {6{pc_valid_i & ~debug_mode_i}};
    end

    for (genvar g = 0; g < 2; g++)
    begin : g_data
        bwu_dmatch u_dm
        (
            .ctrl_i(dctrl[g]),
            .addr_i(daddr[g]),
            .value_i(dval[g]),
            .bus_addr_i(dacc_addr_i),
            .bus_data_i(dacc_data_i),
            .bus_write_i(dacc_write_i),
            .bus_size_i(dacc_size_i),
            .hit_o(data_raw[g])
        );
    end

    // hits, breaks, messages, trace trigger
    always_comb
    begin
        pc_break_d = 1'b0;
        watch_hit_d = 8'h0;
        evo_d = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            pctrl_evo[i] = pctrl[i][`BWU_EVO_BIT];
            if (prog_hit[i] && en_is(pctrl[i], BWU_EN_BRK))
                pc_break_d = 1'b1;
            if (prog_hit[i] && en_is(pctrl[i], BWU_EN_WATCH))
                watch_hit_d[i] = 1'b1;
            if (prog_hit[i] && !en_is(pctrl[i], BWU_EN_OFF)
                && !en_is(pctrl[i], BWU_EN_RSV) && pctrl_evo[i])
                evo_d = 1'b1;
        end
        data_pend_d = data_pend_q;
        data_break_d = 1'b0;
        for (int j = 0; j < 2; j++)
        begin
            pctrl_evo[6+j] = dctrl[j][`BWU_EVO_BIT];
            if (dacc_valid_i && !debug_mode_i && data_raw[j]
                && en_is(dctrl[j], BWU_EN_BRK))
                data_pend_d[j] = 1'b1;
            if (dacc_valid_i && !debug_mode_i && data_raw[j]
                && en_is(dctrl[j], BWU_EN_WATCH))
                watch_hit_d[6+j] = 1'b1;
            if (dacc_valid_i && !debug_mode_i && data_raw[j]
                && !en_is(dctrl[j], BWU_EN_OFF)
                && !en_is(dctrl[j], BWU_EN_RSV) && pctrl_evo[6+j])
                evo_d = 1'b1;
        end
        if (dacc_done_i && data_pend_d != 2'h0)
        begin
            data_break_d = 1'b1;
            data_pend_d = 2'h0;
        end
        evo_d = evo_d & event_out_select_i;
        watch_msg_d = watch_hit_d != 8'h0;
        trace_hit_d = watch_msg_d ? 2'h0 : trace_wp_i;
        trace_msg_d = trace_hit_d != 2'h0;
        wp_ev = {watch_hit_d[7:6], watch_hit_d[5:1], 1'b0};
        pt_d = pt_q;
        dt_d = dt_q;
        keep_d = 1'b1;
        if (sel_hit(trig_q[`BWU_PBEG_HI:`BWU_PBEG_LO], wp_ev))
            pt_d = 1'b1;
        if (sel_hit(trig_q[`BWU_PSTP_HI:`BWU_PSTP_LO], wp_ev))
            pt_d = 1'b0;
        if (sel_hit(trig_q[`BWU_DBEG_HI:`BWU_DBEG_LO], wp_ev))
        begin
            dt_d = 1'b1;
            keep_d = 1'b0;
        end
        if (sel_hit(trig_q[`BWU_DSTP_HI:`BWU_DSTP_LO], wp_ev))
        begin
            dt_d = 1'b0;
            keep_d = 1'b1;
        end
    end

    // register read: one cycle latency
    always_comb
    begin
        rd_mem_d = reg_rd_i && reg_addr_i < 6'h6;
        if (!reg_rd_i)
            rd_reg_d = 32'h0;
        else if (reg_addr_i >= `BWU_PCTRL_BASE
            && reg_addr_i < `BWU_PCTRL_BASE + 6'h6)
            rd_reg_d = ctl_q[reg_addr_i[2:0]];
        else if (reg_addr_i >= `BWU_DADDR_BASE
            && reg_addr_i < `BWU_DCTRL_BASE + 6'h2)
            rd_reg_d = dq_q[3'(reg_addr_i - `BWU_DADDR_BASE)];
        else if (reg_addr_i == `BWU_TRIG_OFF)
            rd_reg_d = trig_q;
        else if (reg_addr_i == `BWU_STAT_OFF)
            rd_reg_d = {28'h0, data_pend_q, dt_q, pt_q};
        else
            rd_reg_d = 32'h0;
        rdata_d = rd_mem_q ? mem_rdata : rd_reg_q;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 8; i++)
                ctl_q[i] <= `BWU_RESET_VAL;
            for (int i = 0; i < 6; i++)
                dq_q[i] <= `BWU_RESET_VAL;
            trig_q <= `BWU_RESET_VAL;
            rd_mem_q <= 1'b0;
            rd_reg_q <= 32'h0;
            data_pend_q <= 2'h0;
            pt_q <= 1'b0;
            dt_q <= 1'b0;
            pc_break_o <= 1'b0;
            data_break_o <= 1'b0;
            watch_hit_o <= 8'h0;
            watch_msg_o <= 1'b0;
            trace_hit_o <= 2'h0;
            trace_msg_o <= 1'b0;
            event_out_pin_o <= 1'b0;
            data_event_keep_o <= 1'b1;
        end
        else
        begin
            ctl_q <= ctl_d;
            dq_q <= dq_d;
            trig_q <= trig_d;
            rd_mem_q <= rd_mem_d;
            rd_reg_q <= rd_reg_d;
            data_pend_q <= data_pend_d;
            pt_q <= pt_d;
            dt_q <= dt_d;
            pc_break_o <= pc_break_d;
            data_break_o <= data_break_d;
            watch_hit_o <= watch_hit_d;
            watch_msg_o <= watch_msg_d;
            trace_hit_o <= trace_hit_d;
            trace_msg_o <= trace_msg_d;
            event_out_pin_o <= evo_d;
            data_event_keep_o <= keep_d;
        end
    end

    assign reg_rdata_o = rdata_d;
    assign prog_trace_en_o = pt_q;
    assign data_trace_en_o = dt_q;
    assign watch_tcode_o = `BWU_TCODE_WH;
    assign trace_tcode_o = `BWU_TCODE_THIT;

    a_range_b_silent: assert property (@(posedge core_clk_i) disable iff
        (rst_i) pctrl[0][`BWU_RMASK_BIT] |=> !watch_hit_o[1])
        else $error("masked b module matched");
    a_trace_suppress: assert property (@(posedge core_clk_i) disable iff
        (rst_i) watch_msg_d |=> !trace_msg_o)
        else $error("trace hit not suppressed");
    a_evo_gate: assert property (@(posedge core_clk_i) disable iff
        (rst_i) !event_out_select_i |=> !event_out_pin_o)
        else $error("event pulse without select");
    a_dbreak_done: assert property (@(posedge core_clk_i) disable iff
        (rst_i) data_break_o |-> $past(dacc_done_i))
        else $error("data break before completion");
    a_trig_rsvd: assert property (@(posedge core_clk_i) disable iff
        (rst_i) trig_q[19:0] == 20'h0)
        else $error("trigger reserved bits set");
    a_tcode_thit: assert property (@(posedge core_clk_i) disable iff
        (rst_i) trace_msg_o |-> trace_tcode_o == 6'd56)
        else $error("trace hit code wrong");
    a_pbrk_en: assert property (@(posedge core_clk_i) disable iff
        (rst_i) pc_break_o |-> $past(pc_valid_i && !debug_mode_i))
        else $error("pc break without valid pc");
    a_dtrace_off: assert property (@(posedge core_clk_i) disable iff
        (rst_i) trig_q == 32'h0 |=> $stable(data_trace_en_o))
        else $error("data trace changed with trigger off");
endmodule // bwu_top

// [bench/bwu_tool.sv]
`timescale 1ns/1ns
// debug tool model: register master on the debug port
module bwu_tool
(
    input wire logic core_clk_i,
    output logic [5:0] reg_addr_o,
    output logic [31:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [31:0] reg_rdata_i
);
    initial
    begin
        reg_addr_o = 6'h00;
        reg_wdata_o = 32'h0000_0000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // one-cycle write; released data shows its inverse
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~d;
    endtask

    // one-cycle read; data stands only in the following cycle
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_o <= 1'b0;
        #1;
        d = reg_rdata_i;
    endtask
endmodule // bwu_tool

// [bench/bwu_top_tb.sv]
`timescale 1ns/1ns
module bwu_top_tb;
    import bwu_pkg::*;
    logic core_clk_i, rst_i, reg_wr_i, reg_rd_i, debug_mode_i;
    logic event_out_select_i, pc_valid_i, dacc_valid_i, dacc_write_i;
    logic dacc_done_i, pc_break_o, data_break_o, watch_msg_o, trace_msg_o;
    logic event_out_pin_o, prog_trace_en_o, data_trace_en_o;
    logic data_event_keep_o;
    logic [5:0] reg_addr_i, watch_tcode_o, trace_tcode_o;
    logic [31:0] reg_wdata_i, reg_rdata_o, pc_i;
    logic [31:0] dacc_addr_i, dacc_data_i, rv;
    logic [1:0] dacc_size_i, trace_wp_i, trace_hit_o;
    logic [7:0] watch_hit_o;
    int failures = 0;
    int n_tests = 0;

    bwu_top i_bwu_top (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .debug_mode_i,
        .event_out_select_i, .pc_valid_i, .pc_i, .dacc_valid_i,
        .dacc_addr_i, .dacc_data_i, .dacc_write_i, .dacc_size_i,
        .dacc_done_i, .trace_wp_i, .pc_break_o, .data_break_o,
        .watch_hit_o, .watch_msg_o, .watch_tcode_o, .trace_hit_o,
        .trace_msg_o, .trace_tcode_o, .event_out_pin_o, .prog_trace_en_o,
        .data_trace_en_o, .data_event_keep_o);
    bwu_tool i_bwu_tool (.core_clk_i, .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));

    always #10 core_clk_i = ~core_clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic w(input logic [5:0] a, input logic [31:0] d);
        i_bwu_tool.wr(a, d);
    endtask

    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        i_bwu_tool.rd(a, rv);
        chk(rv, exp, "register read");
    endtask

    // one executed pc; checks break, event, message and hit vector
    task automatic pc_step(input logic [31:0] pc, input logic [7:0] hit,
        input logic brk, input logic ev);
        @(posedge core_clk_i);
        pc_valid_i <= 1'b1;
        pc_i <= pc;
        @(posedge core_clk_i);
        pc_valid_i <= 1'b0;
        pc_i <= ~pc;
        #1;
        chk({21'h0, pc_break_o, event_out_pin_o, watch_msg_o, watch_hit_o},
            {21'h0, brk, ev, |hit, hit}, "pc match");
    endtask

    // one data access; checks the data module hit bits
    task automatic dstep(input logic [31:0] a, input logic [31:0] d,
        input logic wr, input logic [1:0] sz, input logic [1:0] hit);
        @(posedge core_clk_i);
        dacc_valid_i <= 1'b1;
        dacc_addr_i <= a;
        dacc_data_i <= d;
        dacc_write_i <= wr;
        dacc_size_i <= sz;
        @(posedge core_clk_i);
        dacc_valid_i <= 1'b0;
        dacc_data_i <= ~d;
        #1;
        chk({30'h0, watch_hit_o[7:6]}, {30'h0, hit}, "data match");
    endtask

    task automatic t_regs;
        for (int i = 0; i < 6; i++)
            rchk(6'(i), 32'h0000_0000);
        for (int i = 16; i < 20; i++)
            rchk(6'(i), 32'h0000_0000);
        w(6'h00, 32'ha5a5_5a5a);
        rchk(6'h00, 32'ha5a5_5a5a);
        w(6'h11, 32'h1234_5678);
        rchk(6'h11, 32'h1234_5678);
        w(6'h13, 32'h8765_4321);
        rchk(6'h13, 32'h8765_4321);
        w(6'h08, 32'hffff_ffff);
        rchk(6'h08, 32'hc200_4000);
        w(6'h09, 32'hffff_ffff);
        rchk(6'h09, 32'hc000_4000);
        w(6'h14, 32'hffff_ffff);
        rchk(6'h14, 32'hf0f3_4e00);
        w(6'h16, 32'hffff_ffff);
        rchk(6'h16, 32'hfff0_0000);
        w(6'h3f, 32'hffff_ffff);
        rchk(6'h3f, 32'h0000_0000);
        w(6'h06, 32'hffff_ffff);
        rchk(6'h06, 32'h0000_0000);
        foreach (rv[i])
            if (i < 4)
                w(6'h08 + 6'(i), 32'h0000_0000);
        w(6'h14, 32'h0000_0000);
        w(6'h16, 32'h0000_0000);
        $display("test regs done");
    endtask

    task automatic t_prog;
        w(6'h00, 32'h0000_1200);
        for (int e = 0; e < 4; e++)
        begin
            w(6'h08, {2'(e), 30'h0});
            pc_step(32'h0000_1200, 8'(e == 3), e == 1, 1'b0);
        end
        debug_mode_i <= 1'b1;
        pc_step(32'h0000_1200, 8'h00, 1'b0, 1'b0);
        debug_mode_i <= 1'b0;
        w(6'h01, 32'hffff_ff00);
        w(6'h09, 32'hc000_0000);
        w(6'h08, 32'hc200_0000);
        pc_step(32'h0000_12ab, 8'h01, 1'b0, 1'b0);
        pc_step(32'hffff_ff00, 8'h00, 1'b0, 1'b0);
        pc_step(32'h0000_13ab, 8'h00, 1'b0, 1'b0);
        w(6'h08, 32'hc000_0000);
        pc_step(32'hffff_ff00, 8'h02, 1'b0, 1'b0);
        w(6'h09, 32'h0000_0000);
        event_out_select_i <= 1'b1;
        w(6'h08, 32'hc000_4000);
        pc_step(32'h0000_1200, 8'h01, 1'b0, 1'b1);
        w(6'h08, 32'hc000_0000);
        pc_step(32'h0000_1200, 8'h01, 1'b0, 1'b0);
        event_out_select_i <= 1'b0;
        w(6'h08, 32'hc000_4000);
        pc_step(32'h0000_1200, 8'h01, 1'b0, 1'b0);
        $display("test prog done");
    endtask

    task automatic t_data;
        w(6'h10, 32'h0000_2000);
        w(6'h12, 32'h1122_3344);
        w(6'h14, 32'hd002_0c00);
        dstep(32'h2000, 32'h0, 1'b1, 2'd2, 2'b01);
        dstep(32'h2000, 32'h0, 1'b0, 2'd2, 2'b00);
        dstep(32'h2000, 32'h0, 1'b1, 2'd0, 2'b00);
        w(6'h14, 32'hc002_0000);
        dstep(32'h2000, 32'h0, 1'b0, 2'd1, 2'b01);
        w(6'h14, 32'he002_0800);
        dstep(32'h2000, 32'h0, 1'b0, 2'd0, 2'b01);
        dstep(32'h2000, 32'h0, 1'b1, 2'd2, 2'b00);
        w(6'h14, 32'he0e1_0000);
        dstep(32'h5550, 32'h9999_9944, 1'b1, 2'd2, 2'b01);
        dstep(32'h5550, 32'h9999_9945, 1'b1, 2'd2, 2'b00);
        w(6'h14, 32'he003_0000);
        dstep(32'h2000, 32'h1122_3344, 1'b1, 2'd2, 2'b01);
        dstep(32'h2000, 32'h0000_0000, 1'b1, 2'd2, 2'b00);
        dstep(32'h2004, 32'h1122_3344, 1'b1, 2'd2, 2'b00);
        w(6'h14, 32'h5002_0000);
        dstep(32'h2000, 32'h0, 1'b1, 2'd2, 2'b00);
        chk(data_break_o, 1'b0, "break early");
        @(posedge core_clk_i);
        dacc_done_i <= 1'b1;
        @(posedge core_clk_i);
        dacc_done_i <= 1'b0;
        #1;
        chk(data_break_o, 1'b1, "data break");
        w(6'h14, 32'h0000_0000);
        $display("test data done");
    endtask

    task automatic tstep(input logic [1:0] tw, input logic pcv);
        @(posedge core_clk_i);
        trace_wp_i <= tw;
        pc_valid_i <= pcv;
        pc_i <= 32'h0000_1200;
        @(posedge core_clk_i);
        trace_wp_i <= 2'b00;
        pc_valid_i <= 1'b0;
        #1;
    endtask

    task automatic t_trace;
        w(6'h08, 32'h0000_0000);
        tstep(2'b01, 1'b0);
        chk({trace_msg_o, trace_hit_o, trace_tcode_o},
            {1'b1, 2'b01, 6'd56}, "trace");
        tstep(2'b10, 1'b0);
        chk({trace_msg_o, trace_hit_o, trace_tcode_o},
            {1'b1, 2'b10, 6'd56}, "trace");
        w(6'h08, 32'hc000_0000);
        tstep(2'b11, 1'b1);
        chk({watch_msg_o, trace_msg_o, watch_tcode_o}, {2'b10, 6'd15},
            "trace hidden");
        w(6'h08, 32'h0000_0000);
        $display("test trace done");
    endtask

    task automatic t_trig;
        w(6'h09, 32'hc000_0000);
        w(6'h02, 32'h0000_3000);
        w(6'h0a, 32'hc000_0000);
        w(6'h16, 32'h28a0_0000);
        #1;
        chk({prog_trace_en_o, data_trace_en_o}, 2'b00, "off");
        pc_step(32'hffff_ff00, 8'h02, 1'b0, 1'b0);
        chk(data_event_keep_o, 1'b0, "start dropped");
        @(posedge core_clk_i);
        #1;
        chk({prog_trace_en_o, data_trace_en_o}, 2'b11, "on");
        pc_step(32'h0000_3000, 8'h04, 1'b0, 1'b0);
        chk(data_event_keep_o, 1'b1, "stop kept");
        @(posedge core_clk_i);
        #1;
        chk({prog_trace_en_o, data_trace_en_o}, 2'b00, "stop");
        $display("test trig done");
    endtask

    initial
    begin
        core_clk_i = 1'b0;
        rst_i = 1'b1;
        debug_mode_i = 1'b0;
        event_out_select_i = 1'b0;
        pc_valid_i = 1'b0;
        pc_i = 32'h0000_0000;
        dacc_valid_i = 1'b0;
        dacc_addr_i = 32'h0000_0000;
        dacc_data_i = 32'h0000_0000;
        dacc_write_i = 1'b0;
        dacc_size_i = 2'd0;
        dacc_done_i = 1'b0;
        trace_wp_i = 2'b00;
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_prog();
        t_data();
        t_trace();
        t_trig();
        test_done();
    end

    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        failures++;
        test_done();
    end
endmodule // bwu_top_tb
